// file: rff_match.sv
// One pattern/mask matcher over the first 64 bytes of a frame
`timescale 1ns/1ps
module rff_match
    import rff_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic enable,
    input wire logic [PATTERN_BITS-1:0] pattern,
    input wire logic [PATTERN_BITS-1:0] mask,
    input wire logic [7:0] rx_data,
    input wire logic [5:0] byte_idx,
    input wire logic in_window,
    input wire logic beat,
    input wire logic last,
    output logic match
);
    logic ok_ff;
    logic [7:0] pat_byte;
    logic [7:0] msk_byte;
    logic byte_ok;

    // Byte k of the frame sits in bits 8k+7..8k, bit 0 received first
    assign pat_byte = pattern[{byte_idx, 3'b000} +: 8];
    assign msk_byte = mask[{byte_idx, 3'b000} +: 8];
    // Only mask ones take part in the compare
    assign byte_ok = ((pat_byte ^ rx_data) & msk_byte) == 8'h00;

    // Running result; rearmed at every frame end
    always_ff @(posedge clk_sys) begin
        if (rst || (beat && last)) begin
            ok_ff <= 1'b1;
        end else if (beat && in_window && !byte_ok) begin
            ok_ff <= 1'b0;
        end
    end

    // Current byte folded in so the verdict is ready on the last beat
    assign match = enable && ok_ff && (!in_window || byte_ok);
endmodule

// file: rff_pkg.sv
// Constants for the receive frame filter: register map, fields, reset patterns
package rff_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FEN = 8'h04;
    localparam logic [7:0] REG_UCAST_LO = 8'h08;
    localparam logic [7:0] REG_UCAST_HI = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_PAUSE_LO = 8'h14;
    localparam logic [7:0] REG_PAUSE_HI = 8'h18;
    localparam logic [7:0] REG_PAT_BASE = 8'h40;
    localparam logic [7:0] REG_MSK_BASE = 8'h80;
    localparam logic [1:0] BANK_PAT = 2'h1;
    localparam logic [1:0] BANK_MSK = 2'h2;
    // Control register fields
    localparam int CTRL_IDX_LSB = 0;
    localparam int CTRL_IDX_W = 3;
    localparam int CTRL_BANK_BIT = 8;
    localparam int CTRL_PROMISC_BIT = 31;
    localparam logic [1:0] BRIDGE_IDX_NONE = 2'h3;
    localparam logic [1:0] BRIDGE_IDX_PTP = 2'h0;
    localparam logic [1:0] BRIDGE_IDX_HIGH = 2'h1;
    localparam logic [1:0] BRIDGE_IDX_LOW = 2'h2;
    // Status register fields
    localparam int STAT_DA_LSB = 16;
    localparam int STAT_GOOD_BIT = 20;
    localparam int STAT_PTP_BIT = 21;
    localparam int STAT_AV_BIT = 22;
    // Frame geometry
    localparam int PATTERN_BITS = 512;
    localparam int WINDOW_BYTES = 64;
    localparam int DA_BYTES = 6;
    localparam int BCAST_BITS = 48;
    localparam logic [6:0] WINDOW_END = 7'h40;
    localparam logic [6:0] DA_END = 7'h06;
    // Fixed destination addresses and address register reset values, first received byte in bits 7:0
    localparam logic [47:0] ADDR_BCAST = 48'hFFFFFFFFFFFF;
    localparam logic [47:0] ADDR_MCAST_PAUSE = 48'h010000C28001;
    localparam logic [47:0] PAUSE_ADDR_RST = 48'h000000000000;
    localparam logic [47:0] UCAST_ADDR_RST = 48'h000000000000;
    // Bridging filter reset values, bytes 12..15 of the frame
    localparam int TAG_LSB = 96;
    localparam logic [31:0] CLASS_HIGH_VAL = 32'h02600081;
    localparam logic [31:0] CLASS_LOW_VAL = 32'h02400081;
    localparam logic [31:0] CLASS_MSK = 32'hFFFFFFFF;
    localparam logic [31:0] PTP_VAL = 32'h0000F788;
    localparam logic [31:0] PTP_MSK = 32'h0000FFFF;
endpackage

// file: rff_sink.sv
// Receive-side consumer model: one dedicated queue shared by all user filter hits plus the default queue
`timescale 1ns/1ps
module rff_sink #(
    parameter int NUM_FILTERS = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic result_valid,
    input wire logic accept_good,
    input wire logic [NUM_FILTERS:0] filter_flags,
    output int n_dedicated,
    output int n_default
);
    // Default queue drops frames served elsewhere, so frames are never stored twice
    always @(posedge clk_sys) begin
        if (rst) begin
            n_dedicated <= 0;
            n_default <= 0;
        end else if (result_valid === 1'b1 && accept_good === 1'b1) begin
            if (filter_flags[NUM_FILTERS] === 1'b1) begin
                n_dedicated <= n_dedicated + 1;
            end else begin
                n_default <= n_default + 1;
            end
        end
    end
endmodule

// file: rff_top.sv
// Receive frame filter: fixed address checks, pattern filters, register port
// What this block does
// - Compare destination address with pause, broadcast, unicast, multicast pause addresses.
// - Each filter compares 512 pattern bits with first 512 received bits.
// - Mask bit one: pattern bit must equal received bit.
// - Mask bit zero: that bit is not compared.
// - Up to eight user filters plus three bridging filters when built.
// - One shared pattern/mask register set; control field selects the filter.
// - Promiscuous marks all good frames good; else needs address or user filter match.
// - Each filter has an enable; disabled filters never match.
// - User filters reset to ones in low 48 pattern and mask bits.
// - Match flag vector: one bit per user filter plus top bit.
// - Top bit is set when any user filter matched.
// - Match flags keep working in promiscuous mode.
// - Control bit 8 selects bridging filters by two-bit index; 3 ignored.
// - Bridging index 1 is stream class high, 2 is stream class low.
// - The two stream class filter results are ORed.
// - Class filters reset to tag type 0x0081, tag info 0x0260 / 0x0240.
// - Bridging filters reset for timing and both stream classes, reprogrammable.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module rff_top
    import rff_pkg::*;
#(
    parameter int NUM_FILTERS = 8,
    parameter bit BRIDGE_EN = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic rx_good,
    output logic result_valid,
    output logic accept_good,
    output logic accept_bad,
    output logic [NUM_FILTERS:0] filter_flags,
    output logic da_pause,
    output logic da_bcast,
    output logic da_ucast,
    output logic da_mcast_pause,
    output logic ptp_match,
    output logic av_match
);
    localparam int NT = NUM_FILTERS + 3;
    localparam int SLOT_W = 4;

    logic [PATTERN_BITS-1:0] val_ff [NT];
    logic [PATTERN_BITS-1:0] msk_ff [NT];
    logic [NT-1:0] en_ff;
    logic [CTRL_IDX_W-1:0] idx_ff;
    logic bank_ff;
    logic promisc_ff;
    logic [47:0] ucast_ff;
    logic [47:0] pause_ff;
    logic [31:0] status_ff;
    logic [31:0] reg_rdata_ff;
    logic [6:0] cnt_ff;
    logic [47:0] da_ff;
    logic [NT-1:0] match;
    logic [SLOT_W-1:0] slot;
    logic slot_ok;
    logic in_window;
    logic [3:0] word;
    logic [1:0] bank;
    logic any_user;
    logic fixed_hit;

    // Reset pattern per slot: user filters catch broadcast only
    function automatic logic [PATTERN_BITS-1:0] rst_val(input int s, input bit is_mask);
        logic [PATTERN_BITS-1:0] v;
        v = '0;
        if (s < NUM_FILTERS) begin
            v[BCAST_BITS-1:0] = ADDR_BCAST;
        end else if (s == NUM_FILTERS) begin
            v[TAG_LSB +: 32] = is_mask ? PTP_MSK : PTP_VAL;
        end else if (s == NUM_FILTERS + 1) begin
            v[TAG_LSB +: 32] = is_mask ? CLASS_MSK : CLASS_HIGH_VAL;
        end else begin
            v[TAG_LSB +: 32] = is_mask ? CLASS_MSK : CLASS_LOW_VAL;
        end
        return v;
    endfunction

    // Selected slot; bridging bank maps index onto the three extra slots
    always_comb begin
        if (bank_ff) begin
            slot = SLOT_W'(NUM_FILTERS) + SLOT_W'(idx_ff[1:0]);
            slot_ok = BRIDGE_EN && (idx_ff[1:0] != BRIDGE_IDX_NONE);
        end else begin
            slot = SLOT_W'(idx_ff);
            slot_ok = SLOT_W'(idx_ff) < SLOT_W'(NUM_FILTERS);
        end
    end

    assign word = reg_addr[5:2];
    assign bank = reg_addr[7:6];

    // Control register: index, bank select, promiscuous
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idx_ff <= '0;
            bank_ff <= 1'b0;
            promisc_ff <= 1'b0;
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            idx_ff <= reg_wdata[CTRL_IDX_LSB +: CTRL_IDX_W];
            bank_ff <= reg_wdata[CTRL_BANK_BIT];
            promisc_ff <= reg_wdata[CTRL_PROMISC_BIT];
        end
    end

    // Address registers for the fixed compares
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ucast_ff <= UCAST_ADDR_RST;
            pause_ff <= PAUSE_ADDR_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_UCAST_LO: ucast_ff[31:0] <= reg_wdata;
                REG_UCAST_HI: ucast_ff[47:32] <= reg_wdata[15:0];
                REG_PAUSE_LO: pause_ff[31:0] <= reg_wdata;
                REG_PAUSE_HI: pause_ff[47:32] <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // Per-slot enables; bridging slots come up enabled so timing traffic flows
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int s = 0; s < NT; s++) begin
                en_ff[s] <= BRIDGE_EN && (s >= NUM_FILTERS);
            end
        end else if (reg_wr && reg_addr == REG_FEN && slot_ok) begin
            en_ff[slot] <= reg_wdata[0];
        end
    end

    // Shared pattern and mask window, steered by the selected slot
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int s = 0; s < NT; s++) begin
                val_ff[s] <= rst_val(s, 1'b0);
                msk_ff[s] <= rst_val(s, 1'b1);
            end
        end else if (reg_wr && slot_ok) begin
            if (bank == BANK_PAT) begin
                val_ff[slot][{word, 5'b00000} +: 32] <= reg_wdata;
            end else if (bank == BANK_MSK) begin
                msk_ff[slot][{word, 5'b00000} +: 32] <= reg_wdata;
            end
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata_ff <= '0;
        end else if (reg_rd) begin
            reg_rdata_ff <= '0;
            if (bank == BANK_PAT && slot_ok) begin
                reg_rdata_ff <= val_ff[slot][{word, 5'b00000} +: 32];
            end else if (bank == BANK_MSK && slot_ok) begin
                reg_rdata_ff <= msk_ff[slot][{word, 5'b00000} +: 32];
            end else begin
                case (reg_addr)
                    REG_CTRL: begin
                        reg_rdata_ff[CTRL_IDX_LSB +: CTRL_IDX_W] <= idx_ff;
                        reg_rdata_ff[CTRL_BANK_BIT] <= bank_ff;
                        reg_rdata_ff[CTRL_PROMISC_BIT] <= promisc_ff;
                    end
                    REG_FEN: reg_rdata_ff[0] <= slot_ok && en_ff[slot];
                    REG_UCAST_LO: reg_rdata_ff <= ucast_ff[31:0];
                    REG_UCAST_HI: reg_rdata_ff[15:0] <= ucast_ff[47:32];
                    REG_PAUSE_LO: reg_rdata_ff <= pause_ff[31:0];
                    REG_PAUSE_HI: reg_rdata_ff[15:0] <= pause_ff[47:32];
                    REG_STATUS: reg_rdata_ff <= status_ff;
                    default: reg_rdata_ff <= '0;
                endcase
            end
        end else begin
            reg_rdata_ff <= '0;
        end
    end

    assign reg_rdata = reg_rdata_ff;

    // Byte position within the frame, saturating past the pattern window
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (rx_valid && rx_last) begin
            cnt_ff <= '0;
        end else if (rx_valid && cnt_ff != WINDOW_END) begin
            cnt_ff <= cnt_ff + 7'h01;
        end
    end

    assign in_window = cnt_ff < WINDOW_END;

    // Capture destination address bytes as they arrive
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            da_ff <= '0;
        end else if (rx_valid && cnt_ff < DA_END) begin
            da_ff[{cnt_ff[2:0], 3'b000} +: 8] <= rx_data;
        end
    end

    // Fixed address results, offered to flow control and statistics
    assign da_pause = da_ff == pause_ff;
    assign da_bcast = da_ff == ADDR_BCAST;
    assign da_ucast = da_ff == ucast_ff;
    assign da_mcast_pause = da_ff == ADDR_MCAST_PAUSE;
    assign fixed_hit = da_pause || da_bcast || da_ucast || da_mcast_pause;

    // One matcher per slot
    for (genvar g = 0; g < NT; g++) begin : g_filter
        rff_match u_match (
            .clk_sys(clk_sys),
            .rst(rst),
            .enable(en_ff[g]),
            .pattern(val_ff[g]),
            .mask(msk_ff[g]),
            .rx_data(rx_data),
            .byte_idx(cnt_ff[5:0]),
            .in_window(in_window),
            .beat(rx_valid),
            .last(rx_last),
            .match(match[g])
        );
    end

    // Verdict on the final beat, beside the frame's own good status
    assign result_valid = rx_valid && rx_last;
    assign any_user = |match[NUM_FILTERS-1:0];
    // Bridging slots stay out of the flag vector
    assign filter_flags = result_valid ? {any_user, match[NUM_FILTERS-1:0]} : '0;
    assign ptp_match = result_valid && match[NUM_FILTERS];
    assign av_match = result_valid && (match[NUM_FILTERS + 1] || match[NUM_FILTERS + 2]);
    // Promiscuous only bypasses the accept test, never the flags
    assign accept_good = result_valid && rx_good && (promisc_ff || fixed_hit || any_user);
    assign accept_bad = result_valid && !accept_good;

    // Last verdict kept for software to read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_ff <= '0;
        end else if (result_valid) begin
            status_ff <= '0;
            status_ff[NUM_FILTERS:0] <= filter_flags;
            status_ff[STAT_DA_LSB +: 4] <= {da_mcast_pause, da_ucast, da_bcast, da_pause};
            status_ff[STAT_GOOD_BIT] <= accept_good;
            status_ff[STAT_PTP_BIT] <= ptp_match;
            status_ff[STAT_AV_BIT] <= av_match;
        end
    end

    // Checks on the verdict, the byte counter and the register file
    sequence s_frame_end;
        rx_valid && rx_last;
    endsequence

    sequence s_rst_release;
        $fell(rst);
    endsequence

    property p_disabled_quiet;
        @(posedge clk_sys) disable iff (rst)
        s_frame_end and !en_ff[0] |-> !filter_flags[0];
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled filter matched");

    property p_else_bit;
        @(posedge clk_sys) disable iff (rst)
        s_frame_end |-> filter_flags[NUM_FILTERS] == (|filter_flags[NUM_FILTERS-1:0]);
    endproperty
    a_else_bit: assert property (p_else_bit) else $error("else bit wrong");

    property p_promisc_good;
        @(posedge clk_sys) disable iff (rst)
        s_frame_end and promisc_ff && rx_good |-> accept_good;
    endproperty
    a_promisc_good: assert property (p_promisc_good) else $error("promiscuous good frame rejected");

    property p_bad_frame;
        @(posedge clk_sys) disable iff (rst)
        s_frame_end and !rx_good |-> !accept_good && accept_bad;
    endproperty
    a_bad_frame: assert property (p_bad_frame) else $error("bad frame accepted");

    property p_bcast_da;
        @(posedge clk_sys) disable iff (rst)
        s_frame_end and da_ff == ADDR_BCAST |-> da_bcast && (accept_good == rx_good);
    endproperty
    a_bcast_da: assert property (p_bcast_da) else $error("broadcast not recognised");

    property p_user_reset;
        @(posedge clk_sys)
        s_rst_release |-> val_ff[0][BCAST_BITS-1:0] == ADDR_BCAST
            && msk_ff[0][BCAST_BITS-1:0] == ADDR_BCAST && msk_ff[0][BCAST_BITS] == 1'b0;
    endproperty
    a_user_reset: assert property (p_user_reset) else $error("user filter reset value wrong");

    property p_class_reset;
        @(posedge clk_sys)
        s_rst_release |-> val_ff[NUM_FILTERS + 1][TAG_LSB +: 32] == CLASS_HIGH_VAL
            && val_ff[NUM_FILTERS + 2][TAG_LSB +: 32] == CLASS_LOW_VAL;
    endproperty
    a_class_reset: assert property (p_class_reset) else $error("class filter reset value wrong");

    property p_count_rearm;
        @(posedge clk_sys) disable iff (rst)
        s_frame_end ##1 !rx_valid [*2] |-> cnt_ff == 7'h00;
    endproperty
    a_count_rearm: assert property (p_count_rearm) else $error("byte count not rearmed");

    property p_sel3_ignored;
        @(posedge clk_sys) disable iff (rst)
        reg_wr && bank_ff && idx_ff[1:0] == BRIDGE_IDX_NONE && reg_addr == REG_FEN
            |=> $stable(en_ff);
    endproperty
    a_sel3_ignored: assert property (p_sel3_ignored) else $error("index 3 write took effect");
endmodule

// file: rff_top_tb.sv
// Self-checking bench for the receive frame filter
`timescale 1ns/1ps
module rff_top_tb;
    import rff_pkg::*;
    localparam logic [47:0] DA_UNI = 48'h665544332210;
    localparam logic [47:0] DA_PAU = 48'h0F0E0D0C0B0A;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [7:0] rx_data = 8'h00;
    logic rx_valid = 1'b0;
    logic rx_last = 1'b0;
    logic rx_good = 1'b0;
    logic result_valid, accept_good, accept_bad, ptp_match, av_match;
    logic da_pause, da_bcast, da_ucast, da_mcast_pause;
    logic [8:0] filter_flags;
    logic [31:0] got;
    logic [31:0] seen_res;
    int n_dedicated, n_default;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;

    rff_top #(.NUM_FILTERS(8), .BRIDGE_EN(1'b1)) u_rff_top (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_last(rx_last), .rx_good(rx_good),
        .result_valid(result_valid), .accept_good(accept_good), .accept_bad(accept_bad),
        .filter_flags(filter_flags), .da_pause(da_pause), .da_bcast(da_bcast),
        .da_ucast(da_ucast), .da_mcast_pause(da_mcast_pause), .ptp_match(ptp_match),
        .av_match(av_match)
    );
    rff_sink #(.NUM_FILTERS(8)) u_rff_sink (
        .clk_sys(clk_sys), .rst(rst), .result_valid(result_valid),
        .accept_good(accept_good), .filter_flags(filter_flags),
        .n_dedicated(n_dedicated), .n_default(n_default)
    );

    // 125 MHz clock
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard, far above the thousand or so cycles the run needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // 64-byte frame; tag fills bytes 12..15, first byte in bits 7:0
    task automatic frame(input logic [47:0] da, input logic [31:0] tag, input logic good);
        for (int k = 0; k < 64; k++) begin
            @(posedge clk_sys);
            rx_valid <= 1'b1;
            rx_last <= (k == 63);
            rx_good <= good;
            rx_data <= (k < 6) ? da[8*k +: 8] : (k >= 12 && k < 16) ? tag[8*(k-12) +: 8] :
                (k < 12) ? 8'h02 : 8'h00;
        end
        #1 seen_res = {8'h00, 3'h0, av_match, ptp_match, da_mcast_pause, da_ucast,
            da_bcast, da_pause, accept_bad, accept_good, result_valid, filter_flags};
        @(posedge clk_sys);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
    endtask

    // Reset pattern values, bridging bank selection, refused slot 3, unmapped reads
    task automatic t_reset_regs();
        logic [31:0] tbl [11][3];
        tbl = '{'{32'h0, 8'h00, 32'h0}, '{32'h0, 8'h40, 32'hFFFFFFFF},
            '{32'h0, 8'h44, 32'h0000FFFF}, '{32'h0, 8'h48, 32'h0},
            '{32'h0, 8'h80, 32'hFFFFFFFF}, '{32'h0, 8'h84, 32'h0000FFFF},
            '{32'h101, 8'h4C, 32'h02600081}, '{32'h102, 8'h4C, 32'h02400081},
            '{32'h100, 8'h4C, 32'h0000F788}, '{32'h100, 8'h8C, 32'h0000FFFF},
            '{32'h103, 8'h4C, 32'h0}};
        for (int i = 0; i < 11; i++) begin
            wr(REG_CTRL, tbl[i][0]);
            // Index 3 refuses pattern and enable writes alike
            if (i == 10) begin
                wr(tbl[i][1], 32'h12345678);
                wr(REG_FEN, 32'h0);
            end
            rd(tbl[i][1], got);
            chk(got, tbl[i][2]);
        end
        rd(8'hF0, got);
        chk(got, 32'h0);
        wr(REG_CTRL, 32'h0);
    endtask

    // Broadcast passes by address; filter 0 only flags it once enabled
    task automatic t_bcast();
        frame(ADDR_BCAST, 32'h0, 1'b1);
        chk(seen_res, 32'h00002600);
        wr(REG_FEN, 32'h1);
        frame(ADDR_BCAST, 32'h0, 1'b1);
        chk(seen_res, 32'h00002701);
    endtask

    // VLAN priority-7 match, bits outside the mask ignored
    task automatic t_vlan();
        wr(REG_FEN, 32'h0);
        wr(REG_PAT_BASE + 8'h0C, 32'hE0008100);
        wr(REG_MSK_BASE, 32'h0);
        wr(REG_MSK_BASE + 8'h04, 32'h0);
        wr(REG_MSK_BASE + 8'h0C, 32'hE0FFFF00);
        wr(REG_FEN, 32'h1);
        frame(DA_UNI, 32'hE5008100, 1'b1);
        chk(seen_res, 32'h00000701);
        rd(REG_STATUS, got);
        chk(got, 32'h00100101);
        frame(DA_UNI, 32'hC0008100, 1'b1);
        chk(seen_res, 32'h00000A00);
    endtask

    // Promiscuous: every good frame good, flags unchanged, bad frames stay bad
    task automatic t_promisc();
        wr(REG_CTRL, 32'h80000000);
        frame(DA_UNI, 32'h0, 1'b1);
        chk(seen_res, 32'h00000600);
        frame(DA_UNI, 32'hE0008100, 1'b1);
        chk(seen_res, 32'h00000701);
        frame(DA_UNI, 32'h0, 1'b0);
        chk(seen_res, 32'h00000A00);
        wr(REG_CTRL, 32'h0);
    endtask

    // Both stream classes raise the shared audio/video result; timing slot separate
    task automatic t_bridge();
        // Bridging hits alone do not make a frame good
        frame(DA_UNI, CLASS_HIGH_VAL, 1'b1);
        chk(seen_res, 32'h00020A00);
        frame(DA_UNI, CLASS_LOW_VAL, 1'b1);
        chk(seen_res, 32'h00020A00);
        frame(DA_UNI, PTP_VAL, 1'b1);
        chk(seen_res, 32'h00010A00);
        chk(seen_res[8:0], 9'h000);
    endtask

    // Programmed unicast and pause addresses, fixed multicast pause address
    task automatic t_addr();
        wr(REG_UCAST_LO, DA_UNI[31:0]);
        wr(REG_UCAST_HI, {16'h0000, DA_UNI[47:32]});
        rd(REG_UCAST_HI, got);
        chk(got, 32'h00006655);
        frame(DA_UNI, 32'h0, 1'b1);
        chk(seen_res, 32'h00004600);
        frame(ADDR_MCAST_PAUSE, 32'h0, 1'b1);
        chk(seen_res, 32'h00008600);
        wr(REG_PAUSE_LO, DA_PAU[31:0]);
        wr(REG_PAUSE_HI, {16'h0000, DA_PAU[47:32]});
        // Bad frame to the pause address: recognised but never good
        frame(DA_PAU, 32'h0, 1'b0);
        chk(seen_res, 32'h00001A00);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_regs();
        t_bcast();
        t_vlan();
        t_promisc();
        t_bridge();
        t_addr();
        chk(n_dedicated, 32'd3);
        chk(n_default, 32'd4);
        end_of_test();
    end
endmodule
